/* File: ast_pkg.sv */
package ast_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] AST_OFS_DATA = 8'h00;
  localparam logic [7:0] AST_OFS_IER  = 8'h04;
  localparam logic [7:0] AST_OFS_IIR  = 8'h08;
  localparam logic [7:0] AST_OFS_LCTL = 8'h0C;
  localparam logic [7:0] AST_OFS_MCTL = 8'h10;
  localparam logic [7:0] AST_OFS_LSR  = 8'h14;
  localparam logic [7:0] AST_OFS_MSR  = 8'h18;
  localparam logic [7:0] AST_OFS_BRGL = 8'h1C;
  localparam logic [7:0] AST_OFS_BRGH = 8'h20;

  // Reset values.
  localparam logic [15:0] AST_DIV_RST  = 16'h0002;
  localparam logic [7:0]  AST_LCTL_RST = 8'h03;

  // Line control field positions.
  localparam int AST_LC_STOP2 = 2;
  localparam int AST_LC_PEN   = 3;
  localparam int AST_LC_EVEN  = 4;
  localparam int AST_LC_BRK   = 6;
  localparam int AST_LC_DLAB  = 7;

  // Modem control field positions.
  localparam int AST_MC_DTR  = 0;
  localparam int AST_MC_RTS  = 1;
  localparam int AST_MC_OUT1 = 2;
  localparam int AST_MC_OUT2 = 3;
  localparam int AST_MC_LOOP = 4;

  // Sixteen baud ticks make one bit, the sample point is mid-bit.
  localparam logic [3:0] AST_TICK_LAST = 4'hF;
  localparam logic [3:0] AST_TICK_MID  = 4'h7;
  localparam int         AST_TO_CHARS  = 4;
  localparam int         AST_TICKS_BIT = 16;

  // Interrupt identity codes reported in bits 3:1 of the identity register.
  localparam logic [2:0] AST_ID_LINE = 3'h3;
  localparam logic [2:0] AST_ID_RXD  = 3'h2;
  localparam logic [2:0] AST_ID_TOUT = 3'h6;
  localparam logic [2:0] AST_ID_TXE  = 3'h1;
  localparam logic [2:0] AST_ID_MDM  = 3'h0;

  // One received character with its error marks.
  typedef struct packed {
    logic       brk;
    logic       frm;
    logic       par;
    logic [7:0] data;
  } ast_rx_entry_s;

  typedef enum {AST_TX_IDLE, AST_TX_START, AST_TX_DATA, AST_TX_PAR, AST_TX_STOP} ast_tx_state_e;
  typedef enum {AST_RX_IDLE, AST_RX_START, AST_RX_DATA, AST_RX_PAR, AST_RX_STOP} ast_rx_state_e;

endpackage : ast_pkg

/* File: ast_fifo.sv */
`timescale 1ns/1ps
module ast_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst,
  input  wire logic                 i_clr,
  input  wire logic                 i_push,
  input  wire logic [W-1:0]         i_data,
  input  wire logic                 i_pop,
  output logic      [W-1:0]         o_data,
  output logic      [$clog2(D):0]   o_count
);
  localparam int AW = $clog2(D);

  logic [W-1:0]  mem [D];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;

  // The head is always visible; the caller guards push against full.
  assign o_data = mem[rd_ptr];

  // Storage write.
  always_ff @(posedge i_clk_sys) begin
    if (i_push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  // Pointers and fill level; clear discards everything held.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || i_clr) begin
      wr_ptr  <= '0;
      rd_ptr  <= '0;
      o_count <= '0;
    end else begin
      if (i_push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (i_pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      o_count <= o_count + (AW+1)'(i_push) - (AW+1)'(i_pop);
    end
  end
endmodule : ast_fifo

/* File: ast_uart.sv */
// Contract
// - Separate sixteen-byte transmit and receive FIFOs.
// - Five to eight data bits, chosen by line control, both directions.
// - Parity generated and checked: even, odd or none.
// - Start bit plus one or two stop bits; stop bit checked on receive.
// - Break driven on the output and detected on the input.
// - Holding register write-only; up to sixteen bytes queued in FIFO mode.
// - After reset holding register empty, empty flag set, transmit interrupt pending.
// - Writing a byte clears the pending transmitter-empty interrupt.
// - Characters leave least significant bit first.
// - Serial output idles high when nothing is left to send.
// - Every transmitted bit lasts sixteen baud ticks.
// - Transmit format taken from line control fields.
// - Receive buffer read-only; data-ready set when a byte enters it.
// - Data-ready clears only once every held byte has been read; a receive FIFO clear through the control write also empties it.
// - Unused upper bits of short characters read as zero.
// - Receiver clocked by the sixteen-times baud tick.
// - Receiver aligns to the start-bit falling edge, then assembles a character.
// - Framing, parity, overrun and break conditions are flagged.
// - Two modem outputs and four modem inputs.
// - Any change of a modem input except ring is caught.
// - Ring indicator interrupts only on its trailing edge.
// - Loopback routes transmit data back to the receiver internally.
// - Divisor resets to 0002h; 0001h is valid and bypasses division.
// - Writing either divisor byte reloads the counter and restarts it.
// - Receive timeout after four idle character times below the trigger level.
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module ast_uart (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_rxd,
  output logic             o_txd,
  input  wire logic        i_cts_n,
  input  wire logic        i_dsr_n,
  input  wire logic        i_dcd_n,
  input  wire logic        i_ring_indicator_in_n,
  output logic             o_dtr_n,
  output logic             o_rts_n,
  output logic             o_irq
);
  import ast_pkg::*;

  // length from line control
  // Character length in data bits for a line control value.
  function automatic logic [3:0] data_bits(input logic [7:0] lc);
    data_bits = 4'h5 + {2'b00, lc[1:0]};
  endfunction : data_bits

  // Mask that keeps only the configured data bits.
  function automatic logic [7:0] len_mask(input logic [7:0] lc);
    len_mask = 8'hFF >> (3'h3 - lc[1:0]);
  endfunction : len_mask

  logic [7:0]  ier;
  logic [7:0]  lctl;
  logic [7:0]  mctl;
  logic [7:0]  fctl;
  logic [15:0] divisor;
  logic [15:0] div_cnt;
  logic        tick;
  logic        acc;
  logic        wr;
  logic        rd;
  logic        loop;
  logic        tx_line;
  logic        rx_in;
  logic        rx_prev;

  assign acc  = i_psel && i_penable && o_pready;
  assign wr   = acc && i_pwrite;
  assign rd   = acc && !i_pwrite;
  assign loop = mctl[AST_MC_LOOP];

  ////////////////////////////////////////////////////////////////////////////////
  // Baud divider.

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      div_cnt <= AST_DIV_RST;
      tick    <= 1'b0;
    end else if (wr && lctl[AST_LC_DLAB] &&
                 (i_paddr == AST_OFS_BRGL || i_paddr == AST_OFS_BRGH)) begin
      div_cnt <= (i_paddr == AST_OFS_BRGL) ? {divisor[15:8], i_pwdata[7:0]}
                                            : {i_pwdata[7:0], divisor[7:0]};
      tick    <= 1'b0;
    end else if (div_cnt <= 16'h0001) begin
      // A divisor of one ticks every cycle, so the divider is bypassed.
      div_cnt <= divisor;
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt - 16'h0001;
      tick    <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // FIFOs.

  logic                  fifo_en;
  logic                  tx_push;
  logic                  tx_pop;
  logic [7:0]            tx_head;
  logic [4:0]            tx_count;
  logic                  tx_full;
  logic                  rx_push;
  logic                  rx_pop;
  ast_rx_entry_s         rx_head;
  ast_rx_entry_s         rx_new;
  logic [4:0]            rx_count;
  logic                  rx_full;
  logic [4:0]            rx_trig;

  assign fifo_en = fctl[0];
  // With FIFO mode off each store behaves as a single holding register.
  assign tx_full = fifo_en ? (tx_count == 5'h10) : (tx_count != 5'h00);
  assign rx_full = fifo_en ? (rx_count == 5'h10) : (rx_count != 5'h00);
  assign tx_push = wr && (i_paddr == AST_OFS_DATA) && !lctl[AST_LC_DLAB] && !tx_full;
  assign rx_pop  = rd && (i_paddr == AST_OFS_DATA) && !lctl[AST_LC_DLAB] && (rx_count != 5'h00);
  assign rx_trig = (fctl[7:6] == 2'h0) ? 5'h01 : (fctl[7:6] == 2'h1) ? 5'h04 :
                   (fctl[7:6] == 2'h2) ? 5'h08 : 5'h0E;

  ast_fifo #(.W(8), .D(16)) u_tx_fifo (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_clr     (wr && i_paddr == AST_OFS_IIR && i_pwdata[2]),
    .i_push    (tx_push),
    .i_data    (i_pwdata[7:0]),
    .i_pop     (tx_pop),
    .o_data    (tx_head),
    .o_count   (tx_count)
  );

  ast_fifo #(.W($bits(ast_rx_entry_s)), .D(16)) u_rx_fifo (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_clr     (wr && i_paddr == AST_OFS_IIR && i_pwdata[1]),
    .i_push    (rx_push),
    .i_data    (rx_new),
    .i_pop     (rx_pop),
    .o_data    (rx_head),
    .o_count   (rx_count)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Transmitter.

  ast_tx_state_e tx_st;
  logic [3:0]    tx_tk;
  logic [2:0]    tx_idx;
  logic [7:0]    tx_sh;
  logic          tx_par;
  logic          tx_stop2;
  logic          tx_end;

  assign tx_pop = (tx_st == AST_TX_IDLE) && (tx_count != 5'h00);
  assign tx_end = tick && (tx_tk == AST_TICK_LAST);

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tx_st    <= AST_TX_IDLE;
      tx_tk    <= '0;
      tx_idx   <= '0;
      tx_sh    <= '0;
      tx_par   <= 1'b0;
      tx_stop2 <= 1'b0;
    end else begin
      if (tick) begin
        tx_tk <= tx_tk + 4'h1;
      end
      case (tx_st)
        AST_TX_IDLE: begin
          if (tx_pop) begin
            tx_sh  <= tx_head & len_mask(lctl);
            tx_par <= (^(tx_head & len_mask(lctl))) ^ !lctl[AST_LC_EVEN];
            tx_tk  <= '0;
            tx_idx <= '0;
            tx_st  <= AST_TX_START;
          end
        end
        AST_TX_START: if (tx_end) tx_st <= AST_TX_DATA;
        AST_TX_DATA: begin
          if (tx_end) begin
            tx_sh  <= tx_sh >> 1;
            tx_idx <= tx_idx + 3'h1;
            if ({1'b0, tx_idx} == data_bits(lctl) - 4'h1) begin
              tx_st    <= lctl[AST_LC_PEN] ? AST_TX_PAR : AST_TX_STOP;
              tx_stop2 <= lctl[AST_LC_STOP2];
            end
          end
        end
        AST_TX_PAR: if (tx_end) tx_st <= AST_TX_STOP;
        AST_TX_STOP: begin
          if (tx_end) begin
            tx_stop2 <= 1'b0;
            tx_st    <= tx_stop2 ? AST_TX_STOP : AST_TX_IDLE;
          end
        end
        default: tx_st <= AST_TX_IDLE;
      endcase
    end
  end

  always_comb begin
    case (tx_st)
      AST_TX_START: tx_line = 1'b0;
      AST_TX_DATA:  tx_line = tx_sh[0];
      AST_TX_PAR:   tx_line = tx_par;
      default:      tx_line = 1'b1;
    endcase
  end

  // Output pin and modem outputs; loopback keeps the pins inactive.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_txd   <= 1'b1;
      o_dtr_n <= 1'b1;
      o_rts_n <= 1'b1;
    end else begin
      o_txd   <= loop || (tx_line && !lctl[AST_LC_BRK]);
      o_dtr_n <= loop || !mctl[AST_MC_DTR];
      o_rts_n <= loop || !mctl[AST_MC_RTS];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receiver.

  ast_rx_state_e rx_st;
  logic [3:0]    rx_tk;
  logic [2:0]    rx_idx;
  logic [7:0]    rx_sh;
  logic          rx_pbit;
  logic          oe;
  logic          oe_set;
  logic          rx_done;

  assign rx_in = loop ? (tx_line && !lctl[AST_LC_BRK]) : i_rxd;
  assign rx_done = (rx_st == AST_RX_STOP) && tick && (rx_tk == AST_TICK_LAST);
  assign rx_push = rx_done && !rx_full;
  assign oe_set  = rx_done && rx_full;

  always_comb begin
    rx_new.data = (rx_sh >> (4'h8 - data_bits(lctl))) & len_mask(lctl);
    rx_new.par  = lctl[AST_LC_PEN] &&
                  (rx_pbit != ((^rx_new.data) ^ !lctl[AST_LC_EVEN]));
    rx_new.frm  = !rx_in;
    rx_new.brk  = !rx_in && (rx_new.data == 8'h00) && !(lctl[AST_LC_PEN] && rx_pbit);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rx_st   <= AST_RX_IDLE;
      rx_tk   <= '0;
      rx_idx  <= '0;
      rx_sh   <= '0;
      rx_pbit <= 1'b0;
      rx_prev <= 1'b1;
    end else if (tick) begin
      rx_prev <= rx_in;
      rx_tk   <= rx_tk + 4'h1;
      case (rx_st)
        AST_RX_IDLE: begin
          if (rx_prev && !rx_in) begin
            rx_tk <= 4'h1;
            rx_st <= AST_RX_START;
          end
        end
        AST_RX_START: begin
          if (rx_tk == AST_TICK_MID) begin
            rx_tk  <= '0;
            rx_idx <= '0;
            rx_st  <= rx_in ? AST_RX_IDLE : AST_RX_DATA;
          end
        end
        AST_RX_DATA: begin
          if (rx_tk == AST_TICK_LAST) begin
            rx_sh  <= {rx_in, rx_sh[7:1]};
            rx_idx <= rx_idx + 3'h1;
            if ({1'b0, rx_idx} == data_bits(lctl) - 4'h1) begin
              rx_st <= lctl[AST_LC_PEN] ? AST_RX_PAR : AST_RX_STOP;
            end
          end
        end
        AST_RX_PAR: begin
          if (rx_tk == AST_TICK_LAST) begin
            rx_pbit <= rx_in;
            rx_st   <= AST_RX_STOP;
          end
        end
        AST_RX_STOP: if (rx_tk == AST_TICK_LAST) rx_st <= AST_RX_IDLE;
        default: rx_st <= AST_RX_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status flags.

  logic [4:0] err_cnt;
  logic       head_err;
  logic       ls_seen;
  logic       rd_lsr;
  logic       tx_holding_empty_flag_int;
  logic       tout;
  logic [9:0] to_cnt;
  logic [9:0] to_lim;
  logic [3:0] mdm_now;
  logic [3:0] mdm_prev;
  logic [3:0] mdm_delta;
  logic [2:0] iir_id;
  logic       any_int;

  assign head_err = (rx_count != 5'h00) && (rx_head.par || rx_head.frm || rx_head.brk);
  assign rd_lsr   = rd && (i_paddr == AST_OFS_LSR);
  assign to_lim   = 10'(AST_TO_CHARS * AST_TICKS_BIT) *
                    10'(4'h2 + data_bits(lctl) + {3'h0, lctl[AST_LC_PEN]});

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      oe      <= 1'b0;
      ls_seen <= 1'b0;
      err_cnt <= '0;
    end else begin
      oe      <= oe_set || (oe && !rd_lsr);
      ls_seen <= !rx_pop && (ls_seen || rd_lsr);
      err_cnt <= err_cnt + 5'(rx_push && (rx_new.par || rx_new.frm || rx_new.brk))
                         - 5'(rx_pop && head_err);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tx_holding_empty_flag_int <= 1'b1;
    end else if (tx_pop && tx_count == 5'h01 && !tx_push) begin
      tx_holding_empty_flag_int <= 1'b1;
    end else if (tx_push || (rd && i_paddr == AST_OFS_IIR && iir_id == AST_ID_TXE)) begin
      tx_holding_empty_flag_int <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst || rx_push || rx_pop || rx_count == 5'h00) begin
      to_cnt <= '0;
      tout   <= tout && (rx_count != 5'h00) && !i_rst;
    end else if (tick && rx_count < rx_trig) begin
      if (to_cnt >= to_lim - 10'h001) begin
        tout <= 1'b1;
      end else begin
        to_cnt <= to_cnt + 10'h001;
      end
    end
  end

  // four modem inputs, looped from the outputs in loopback
  assign mdm_now = loop ? {mctl[AST_MC_OUT2], mctl[AST_MC_OUT1],
                           mctl[AST_MC_DTR], mctl[AST_MC_RTS]}
                        : {!i_dcd_n, !i_ring_indicator_in_n, !i_dsr_n, !i_cts_n};

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      mdm_prev  <= '0;
      mdm_delta <= '0;
    end else begin
      mdm_prev  <= mdm_now;
      mdm_delta <= ((mdm_now ^ mdm_prev) & 4'hB) | {1'b0, mdm_prev[2] & !mdm_now[2], 2'b00} |
                   (mdm_delta & {4{!(rd && i_paddr == AST_OFS_MSR)}});
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt identity and APB slave.

  logic [7:0] lsr;

  // data ready when a byte is held
  assign lsr = {(err_cnt != 5'h00), (tx_count == 5'h00 && tx_st == AST_TX_IDLE),
                !tx_full, rx_head.brk && rx_count != 5'h00,
                rx_head.frm && rx_count != 5'h00, rx_head.par && rx_count != 5'h00,
                oe, rx_count != 5'h00};

  // Priority: line errors, data, timeout, holding empty, modem.
  always_comb begin
    any_int = 1'b1;
    iir_id  = AST_ID_MDM;
    if (ier[2] && (oe || (head_err && !ls_seen))) iir_id = AST_ID_LINE;
    else if (ier[0] && rx_count >= (fifo_en ? rx_trig : 5'h01)) iir_id = AST_ID_RXD;
    else if (ier[0] && tout) iir_id = AST_ID_TOUT;
    else if (ier[1] && tx_holding_empty_flag_int) iir_id = AST_ID_TXE;
    else if (ier[3] && mdm_delta != 4'h0) iir_id = AST_ID_MDM;
    else any_int = 1'b0;
  end

  // Control registers; divisor bytes only writable with the latch bit set.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ier     <= '0;
      lctl    <= AST_LCTL_RST;
      mctl    <= '0;
      fctl    <= '0;
      divisor <= AST_DIV_RST;
    end else if (wr) begin
      case (i_paddr)
        AST_OFS_IER:  ier  <= {4'h0, i_pwdata[3:0]};
        AST_OFS_IIR:  fctl <= {i_pwdata[7:6], 5'h00, i_pwdata[0]};
        AST_OFS_LCTL: lctl <= i_pwdata[7:0];
        AST_OFS_MCTL: mctl <= {3'h0, i_pwdata[4:0]};
        AST_OFS_BRGL: if (lctl[AST_LC_DLAB]) divisor[7:0] <= i_pwdata[7:0];
        AST_OFS_BRGH: if (lctl[AST_LC_DLAB]) divisor[15:8] <= i_pwdata[7:0];
        default: ;
      endcase
    end
  end

  // One wait state: data is latched in the first access cycle.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
      o_irq     <= 1'b0;
    end else begin
      o_irq     <= any_int;
      o_pready  <= i_psel && i_penable && !o_pready;
      o_pslverr <= 1'b0;
      if (i_psel && i_penable && !o_pready) begin
        o_prdata <= '0;
        case (i_paddr)
          AST_OFS_DATA: if (!i_pwrite) o_prdata[7:0] <= rx_head.data;
          AST_OFS_IER:  o_prdata[7:0] <= ier;
          AST_OFS_IIR:  o_prdata[7:0] <= {fifo_en, fifo_en, 2'h0, iir_id, !any_int};
          AST_OFS_LCTL: o_prdata[7:0] <= lctl;
          AST_OFS_MCTL: o_prdata[7:0] <= mctl;
          AST_OFS_LSR:  o_prdata[7:0] <= lsr;
          AST_OFS_MSR:  o_prdata[7:0] <= {mdm_now, mdm_delta};
          AST_OFS_BRGL: o_prdata[7:0] <= divisor[7:0];
          AST_OFS_BRGH: o_prdata[7:0] <= divisor[15:8];
          default:      o_pslverr <= 1'b1;
        endcase
      end
    end
  end
endmodule : ast_uart

/* File: ast_uart_checker.sv */
`timescale 1ns/1ps
// Watches bus answers and serial line timing at the top ports only.
module ast_uart_checker (
  input wire logic        i_clk_sys,
  input wire logic        i_rst,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic [7:0]  i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pready,
  input wire logic        o_pslverr,
  input wire logic        o_txd,
  input wire logic        o_dtr_n,
  input wire logic        o_rts_n,
  input wire logic        o_irq
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  chk_ready_wait: assert property (
    i_psel && i_penable && !$past(i_penable) |-> !o_pready ##1 o_pready)
    else $error("ready not after one wait cycle");
  chk_ready_held: assert property (
    o_pready |-> i_psel && i_penable)
    else $error("ready outside an access");
  chk_ready_pulse: assert property (
    o_pready |=> !o_pready)
    else $error("ready longer than one cycle");
  chk_bad_addr: assert property (
    o_pready && i_paddr > 8'h20 |-> o_pslverr && o_prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_upper_zero: assert property (
    o_pready |-> o_prdata[31:8] == 24'h0)
    else $error("read data above bit 7 not zero");
  // A bit lasts at least sixteen cycles, the fastest divisor being one.
  chk_low_len: assert property (
    $fell(o_txd) |-> (!o_txd) [*8] ##1 (!o_txd) [*8])
    else $error("low level shorter than a bit");
  chk_high_len: assert property (
    $rose(o_txd) |-> o_txd [*8] ##1 o_txd [*8])
    else $error("high level shorter than a bit");
  chk_reset_idle: assert property (disable iff (1'h0)
    i_rst |=> o_txd && o_dtr_n && o_rts_n && !o_pready && !o_irq)
    else $error("outputs not idle after reset");
endmodule : ast_uart_checker
//////////////////////////////
bind ast_uart ast_uart_checker chk_i (.i_clk_sys, .i_rst, .i_psel, .i_penable, .i_paddr,
  .o_prdata, .o_pready, .o_pslverr, .o_txd, .o_dtr_n, .o_rts_n, .o_irq);

/* File: ast_serial_partner.sv */
`timescale 1ns/1ps
// Remote serial device; the bench runs divisor one, so a bit is sixteen cycles.
module ast_serial_partner (
  input  wire logic i_clk_sys,
  input  wire logic i_txd,
  output logic      o_rxd
);
  import ast_pkg::*;
  initial o_rxd = 1'h1;

  // Parity of the masked character; even makes the count of ones even.
  function automatic logic par(input logic [7:0] lc, input logic [7:0] d);
    return lc[4] ? ^d : ~^d;
  endfunction : par

  // Holds one level on the line for a full bit time.
  task automatic put(input logic b);
    o_rxd <= b;
    repeat (AST_TICKS_BIT) @(posedge i_clk_sys);
  endtask : put

  // Mode 1 spoils the stop bit, mode 2 holds the whole frame low as a break.
  task automatic send(input logic [7:0] lc, input logic [7:0] d, input logic [1:0] m);
    d = (m == 2'h2) ? 8'h00 : d & (8'hFF >> (2'h3 - lc[1:0]));
    put(1'h0);
    for (int i = 0; i < 5 + lc[1:0]; i++) put(d[i]);
    if (lc[3]) put(par(lc, d) & (m != 2'h2));
    put(m == 2'h0);
    if (lc[2]) put(m == 2'h0);
    put(1'h1);
  endtask : send

  // Samples mid-bit; ok drops on a bad start, parity or stop bit.
  task automatic recv(input logic [7:0] lc, output logic [7:0] d, output logic ok);
    d = 8'h00;
    @(negedge i_txd);
    repeat (AST_TICKS_BIT / 2) @(posedge i_clk_sys);
    ok = !i_txd;
    for (int i = 0; i < 6 + lc[1:0] + lc[3] + lc[2]; i++) begin
      repeat (AST_TICKS_BIT) @(posedge i_clk_sys);
      if (i < 5 + lc[1:0]) d[i] = i_txd;
      else if (lc[3] && i == 5 + lc[1:0]) ok &= i_txd == par(lc, d);
      else ok &= i_txd;
    end
  endtask : recv

  // A low pulse of n cycles, far shorter than a start bit.
  task automatic pulse(input int n);
    o_rxd <= 1'h0;
    repeat (n) @(posedge i_clk_sys);
    o_rxd <= 1'h1;
  endtask : pulse
endmodule : ast_serial_partner

/* File: test_async_serial_transceiver.sv */
`timescale 1ns/1ps
module test_async_serial_transceiver;
  import ast_pkg::*;
  logic        i_clk_sys = 1'h0, i_rst = 1'h1, i_psel = 1'h0, i_penable = 1'h0;
  logic        i_pwrite = 1'h0, i_cts_n = 1'h1, i_ring_indicator_in_n = 1'h1;
  logic        i_dsr_n = 1'h1, i_dcd_n = 1'h1;
  logic [7:0]  i_paddr = 8'h00, lc, pd, msk;
  logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
  logic        i_rxd, o_txd, o_pready, o_pslverr, o_dtr_n, o_rts_n, o_irq, pok, err;
  int          n_fail = 0, n_tests = 0;

  ast_uart dut (.i_clk_sys, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_rxd, .o_txd, .i_cts_n, .i_dsr_n, .i_dcd_n,
    .i_ring_indicator_in_n, .o_dtr_n, .o_rts_n, .o_irq);
  ast_serial_partner far (.i_clk_sys, .i_txd(o_txd), .o_rxd(i_rxd));

  // Free-running system clock at 100 MHz.
  always #5 i_clk_sys = ~i_clk_sys;
  //////////////////////////////
  // One transfer; the request stands until pready is sampled high.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    i_psel <= 1'h1;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= {24'h0, d};
    @(posedge i_clk_sys);
    i_penable <= 1'h1;
    do @(posedge i_clk_sys); while (o_pready !== 1'h1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask : acc

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    acc(1'h0, a, 8'h00);
    chk(rd, e);
  endtask : rchk

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // Main sequence; divisor one keeps every bit at sixteen cycles.
  initial begin
    repeat (3) @(posedge i_clk_sys);
    i_rst <= 1'h0;
    rchk(AST_OFS_LSR, 32'h60);
    acc(1'h1, AST_OFS_LCTL, 8'h83);
    rchk(AST_OFS_BRGL, 32'h02);
    rchk(AST_OFS_BRGH, 32'h00);
    acc(1'h1, AST_OFS_BRGL, 8'h01);
    rchk(8'h24, 32'h0);
    chk({31'h0, err}, 32'h1);
    acc(1'h1, AST_OFS_LCTL, 8'h03);
    acc(1'h1, AST_OFS_IER, 8'h02);
    repeat (2) @(posedge i_clk_sys);
    chk({31'h0, o_irq}, 32'h1);
    // The second byte waits in the store while the first leaves.
    fork
      begin
        acc(1'h1, AST_OFS_DATA, 8'h55);
        acc(1'h1, AST_OFS_DATA, 8'hA3);
        repeat (2) @(posedge i_clk_sys);
        chk({31'h0, o_irq}, 32'h0);
      end
      begin
        far.recv(8'h03, pd, pok);
        chk({24'h0, pd}, 32'h55);
        far.recv(8'h03, pd, pok);
        chk({24'h0, pd}, 32'hA3);
      end
    join
    // Every length, with parity and stop variants.
    for (int i = 0; i < 4; i++) begin
      repeat (16) @(posedge i_clk_sys);
      lc = {3'h0, i[1], i[0], i[0], i[1:0]};
      msk = 8'hFF >> (3 - i);
      acc(1'h1, AST_OFS_LCTL, lc);
      fork
        acc(1'h1, AST_OFS_DATA, 8'hB6);
        far.recv(lc, pd, pok);
      join
      chk({23'h0, pd, pok}, {23'h0, 8'hB6 & msk, 1'h1});
      far.send(lc, 8'hFF, 2'h0);
      rchk(AST_OFS_LSR, 32'h61);
      rchk(AST_OFS_DATA, {24'h0, msk});
      rchk(AST_OFS_LSR, 32'h60);
    end
    // A break holds the output low until line control releases it.
    acc(1'h1, AST_OFS_LCTL, 8'h43);
    repeat (20) @(posedge i_clk_sys);
    chk({31'h0, o_txd}, 32'h0);
    // Overrun, framing error and break on the input.
    acc(1'h1, AST_OFS_LCTL, 8'h03);
    far.send(8'h03, 8'h11, 2'h0);
    far.send(8'h03, 8'h22, 2'h0);
    rchk(AST_OFS_LSR, 32'h63);
    rchk(AST_OFS_DATA, 32'h11);
    far.send(8'h03, 8'h5A, 2'h1);
    acc(1'h0, AST_OFS_LSR, 8'h00);
    chk(rd & 32'h0F, 32'h09);
    acc(1'h0, AST_OFS_DATA, 8'h00);
    far.send(8'h03, 8'h00, 2'h2);
    acc(1'h0, AST_OFS_LSR, 8'h00);
    chk(rd & 32'h11, 32'h11);
    acc(1'h0, AST_OFS_DATA, 8'h00);
    // Data-ready stands until the last queued byte is read.
    acc(1'h1, AST_OFS_IIR, 8'h01);
    far.send(8'h03, 8'h33, 2'h0);
    far.send(8'h03, 8'h44, 2'h0);
    rchk(AST_OFS_DATA, 32'h33);
    rchk(AST_OFS_LSR, 32'h61);
    rchk(AST_OFS_DATA, 32'h44);
    rchk(AST_OFS_LSR, 32'h60);
    // One byte under a trigger of four times out after four idle characters.
    acc(1'h1, AST_OFS_IER, 8'h01);
    acc(1'h1, AST_OFS_IIR, 8'h41);
    far.send(8'h03, 8'h66, 2'h0);
    rchk(AST_OFS_IIR, 32'hC1);
    repeat (700) @(posedge i_clk_sys);
    rchk(AST_OFS_IIR, 32'hCC);
    rchk(AST_OFS_DATA, 32'h66);
    // A short low pulse is no start bit, so nothing is received.
    far.pulse(4);
    repeat (200) @(posedge i_clk_sys);
    rchk(AST_OFS_LSR, 32'h60);
    // Modem outputs, a line change, and ring edges.
    acc(1'h1, AST_OFS_MCTL, 8'h03);
    i_cts_n <= 1'h0;
    repeat (8) @(posedge i_clk_sys);
    chk({30'h0, o_dtr_n, o_rts_n}, 32'h0);
    rchk(AST_OFS_MSR, 32'h11);
    i_ring_indicator_in_n <= 1'h0;
    repeat (8) @(posedge i_clk_sys);
    rchk(AST_OFS_MSR, 32'h50);
    i_ring_indicator_in_n <= 1'h1;
    repeat (8) @(posedge i_clk_sys);
    rchk(AST_OFS_MSR, 32'h14);
    // Loopback returns the byte; the bound stops a lost character.
    acc(1'h1, AST_OFS_MCTL, 8'h13);
    acc(1'h1, AST_OFS_DATA, 8'hC3);
    rd = 32'h0;
    for (int k = 0; k < 200 && rd[0] !== 1'h1; k++) acc(1'h0, AST_OFS_LSR, 8'h00);
    rchk(AST_OFS_DATA, 32'hC3);
    chk({30'h0, o_dtr_n, o_rts_n}, 32'h3);
    results();
  end

  // The run needs well under ten thousand cycles; this cuts a hang short.
  initial begin
    repeat (30000) @(posedge i_clk_sys);
    n_fail++;
    results();
  end
endmodule : test_async_serial_transceiver
